// *** pid_pkg.sv ***
// package: constants and carrier types for the closed-loop position regulator
package pid_pkg;

  // clock and control period
  localparam int unsigned CLK_HZ         = 25000000;
  localparam int unsigned PERIOD_US      = 1000;
  localparam int unsigned TICK_CYCLES    = (CLK_HZ / 1000000) * PERIOD_US;

  // supervisor persistence times in ms, counted in control periods
  localparam int unsigned LVL1_MS        = 250;
  localparam int unsigned LVL2_MS        = 500;
  localparam int unsigned LVL3_MS        = 1000;
  localparam int unsigned TICKS_PER_MS   = 1000 / PERIOD_US;
  localparam logic [10:0] LVL1_TICKS     = 11'(LVL1_MS * TICKS_PER_MS);
  localparam logic [10:0] LVL2_TICKS     = 11'(LVL2_MS * TICKS_PER_MS);
  localparam logic [10:0] LVL3_TICKS     = 11'(LVL3_MS * TICKS_PER_MS);

  // supervisor error thresholds
  localparam logic [11:0] LVL1_ERR       = 12'h064;
  localparam logic [11:0] LVL2_ERR       = 12'h0FA;
  localparam logic [11:0] LVL3_ERR       = 12'h1F4;

  // signed feedback / command / power range
  localparam logic signed [15:0] POS_MAX = 16'sh03E8;
  localparam logic signed [15:0] POS_MIN = -16'sh03E8;

  // register offsets
  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_KP     = 4'h1;
  localparam logic [3:0] OFS_KI     = 4'h2;
  localparam logic [3:0] OFS_KD     = 4'h3;
  localparam logic [3:0] OFS_ILIM   = 4'h4;
  localparam logic [3:0] OFS_CMD0   = 4'h5;
  localparam logic [3:0] OFS_CMD1   = 4'h6;
  localparam logic [3:0] OFS_STAT   = 4'h7;
  localparam logic [3:0] OFS_MASK   = 4'h8;
  localparam logic [3:0] OFS_PWR0   = 4'h9;
  localparam logic [3:0] OFS_PWR1   = 4'hA;
  localparam logic [3:0] OFS_ERR0   = 4'hB;
  localparam logic [3:0] OFS_ERR1   = 4'hC;

  // ctrl register fields
  localparam int unsigned CTRL_CL0  = 0;
  localparam int unsigned CTRL_CL1  = 1;
  localparam int unsigned CTRL_TRK0 = 2;
  localparam int unsigned CTRL_TRK1 = 3;
  localparam int unsigned CTRL_SENS = 4;

  // status bits: loop error per channel, tick
  localparam int unsigned ST_LERR0  = 0;
  localparam int unsigned ST_LERR1  = 1;
  localparam int unsigned ST_TICK   = 2;

  // reset values
  localparam logic [31:0] CTRL_RST  = 32'h0000_0010;
  localparam logic [15:0] KP_RST    = 16'h0100;
  localparam logic [15:0] ILIM_RST  = 16'h03E8;

  // fixed point: gains are 8.8
  localparam int unsigned GAIN_FRAC = 8;

  // loop phases
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_CALC = 2'b01,
    PH_OUT  = 2'b10
  } phase_t;

  // register port request
  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  // per-channel feedback sample
  typedef struct packed {
    logic signed [15:0] pos;
    logic signed [15:0] traj;
  } chan_in_t;

endpackage : pid_pkg

// *** closed_loop_position_pid.sv ***
// two-channel closed-loop position regulator with loop-error supervisor
`timescale 1ns/10ps
`default_nettype none

module closed_loop_position_pid (
  // clock and reset
  input  wire logic                    mclk_in,
  input  wire logic                    reset_n_in,
  // register port
  input  wire pid_pkg::reg_req_t       reg_req_in,
  output logic [31:0]                  reg_rdata_out,
  // feedback and trajectory per channel
  input  wire pid_pkg::chan_in_t       chan0_in,
  input  wire pid_pkg::chan_in_t       chan1_in,
  // power stage
  output logic signed [15:0]           power0_out,
  output logic signed [15:0]           power1_out,
  output logic [1:0]                   loop_err_out,
  // interrupt
  output logic                         irq_out
);

  // period timing, counted from the edge that raises tick_r:
  //   +1 desired position latched, phase enters calc
  //   +2 error formed from the feedback seen then
  //   +3 integrator, history and power register updated
  //   +4 power reaches the output pins
  // the power stage so sees one new value per period and holds it until the next,
  // or until an opened loop or a fault zeroes power_r a cycle later; nothing is queued in between

  // saturate a wide value to the command range
  // products stay at 48 bits so no term wraps before this clamp
  function automatic logic signed [15:0] sat_cmd(input logic signed [47:0] v);
    if (v > 48'(pid_pkg::POS_MAX)) begin
      sat_cmd = pid_pkg::POS_MAX;
    end else if (v < 48'(pid_pkg::POS_MIN)) begin
      sat_cmd = pid_pkg::POS_MIN;
    end else begin
      sat_cmd = v[15:0];
    end
  endfunction : sat_cmd

  // magnitude of an error value
  // saturates at the field width; every threshold sits far below it
  function automatic logic [11:0] err_mag(input logic signed [15:0] e);
    logic signed [15:0] a;
    a = (e < 0) ? -e : e;
    err_mag = (a > 16'sh0FFF) ? 12'hFFF : a[11:0];
  endfunction : err_mag

  // registers, by word index:
  //   0 control: closed loop and tracking per channel, sensitivity
  //   1 to 3 shared gains, signed 8.8
  //   4 integrator limit, 15 bit magnitude
  //   5, 6 position commands, clamped to full scale on write
  //   7 status, write one to clear; reads also show live faults
  //   8 interrupt mask
  //   9 to 12 power and error per channel, read only
  logic [31:0]        ctrl_r;
  logic signed [15:0] kp_r;
  logic signed [15:0] ki_r;
  logic signed [15:0] kd_r;
  logic signed [15:0] ilim_r;
  logic signed [15:0] cmd_r [2];
  logic [1:0]         cmd_new_r;
  logic [2:0]         stat_r;
  logic [2:0]         mask_r;

  // loop state
  // per-channel arrays are indexed by channel number throughout
  logic [14:0]        tick_cnt_r;
  logic               tick_r;
  pid_pkg::phase_t    phase_r;
  logic signed [15:0] desired_r [2];
  logic signed [15:0] err_r [2];
  logic signed [15:0] prev_err_r [2];
  logic signed [31:0] integ_r [2];
  logic signed [15:0] power_r [2];
  logic [10:0]        persist_r [2];
  logic [1:0]         fault_r;
  logic [1:0]         fault_set;

  logic signed [15:0] fb [2];
  logic signed [15:0] traj [2];
  logic [1:0]         closed;
  logic [1:0]         tracking;
  logic [1:0]         sens;
  logic [11:0]        lim_err;
  logic [10:0]        lim_ticks;
  logic               wr_ok;

  // feedback clamped into the signed command range
  assign fb[0]    = sat_cmd(48'(chan0_in.pos));
  assign fb[1]    = sat_cmd(48'(chan1_in.pos));
  // trajectory clamped too, so desired minus feedback cannot wrap at 16 bits
  assign traj[0]  = sat_cmd(48'(chan0_in.traj));
  assign traj[1]  = sat_cmd(48'(chan1_in.traj));
  assign closed   = {ctrl_r[pid_pkg::CTRL_CL1], ctrl_r[pid_pkg::CTRL_CL0]};
  assign tracking = {ctrl_r[pid_pkg::CTRL_TRK1], ctrl_r[pid_pkg::CTRL_TRK0]};
  assign sens     = ctrl_r[pid_pkg::CTRL_SENS +: 2];
  assign wr_ok    = reg_req_in.wr;

  // sensitivity level picks threshold and persistence; level 0 reads as level 1
  // treating the undefined level as the most sensitive one fails safe
  always_comb begin
    case (sens)
      2'h2: begin
        lim_err   = pid_pkg::LVL2_ERR;
        lim_ticks = pid_pkg::LVL2_TICKS;
      end
      2'h3: begin
        lim_err   = pid_pkg::LVL3_ERR;
        lim_ticks = pid_pkg::LVL3_TICKS;
      end
      default: begin
        lim_err   = pid_pkg::LVL1_ERR;
        lim_ticks = pid_pkg::LVL1_TICKS;
      end
    endcase
  end

  // 1 ms control tick
  // the first tick falls a full period after reset, once the feedback has settled
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      tick_cnt_r <= 15'h0000;
      tick_r     <= 1'b0;
    end else if (tick_cnt_r == 15'(pid_pkg::TICK_CYCLES - 1)) begin
      tick_cnt_r <= 15'h0000;
      tick_r     <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 15'h0001;
      tick_r     <= 1'b0;
    end
  end

  // configuration registers; gains are one shared set for both channels
  // control keeps only its six defined bits, so reads never show stray ones
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      ctrl_r <= pid_pkg::CTRL_RST;
      kp_r   <= pid_pkg::KP_RST;
      ki_r   <= 16'h0000;
      kd_r   <= 16'h0000;
      ilim_r <= pid_pkg::ILIM_RST;
      mask_r <= 3'h0;
    end else if (wr_ok) begin
      case (reg_req_in.addr)
        pid_pkg::OFS_CTRL: ctrl_r <= {26'h0, reg_req_in.wdata[5:0]};
        pid_pkg::OFS_KP:   kp_r   <= reg_req_in.wdata[15:0];
        pid_pkg::OFS_KI:   ki_r   <= reg_req_in.wdata[15:0];
        pid_pkg::OFS_KD:   kd_r   <= reg_req_in.wdata[15:0];
        pid_pkg::OFS_ILIM: ilim_r <= {1'b0, reg_req_in.wdata[14:0]};
        pid_pkg::OFS_MASK: mask_r <= reg_req_in.wdata[2:0];
        default: ;
      endcase
    end
  end

  // position commands; a write flags a new destination
  // clamping on entry keeps tracking from aiming past what feedback can report
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      cmd_r[0]  <= 16'h0000;
      cmd_r[1]  <= 16'h0000;
      cmd_new_r <= 2'h0;
    end else begin
      if (wr_ok && reg_req_in.addr == pid_pkg::OFS_CMD0) begin
        cmd_r[0] <= sat_cmd(48'(signed'(reg_req_in.wdata[15:0])));
      end
      if (wr_ok && reg_req_in.addr == pid_pkg::OFS_CMD1) begin
        cmd_r[1] <= sat_cmd(48'(signed'(reg_req_in.wdata[15:0])));
      end
      // a new write during the consuming tick keeps the flag for the next period
      cmd_new_r[0] <= (cmd_new_r[0] & ~tick_r) | (wr_ok && reg_req_in.addr == pid_pkg::OFS_CMD0);
      cmd_new_r[1] <= (cmd_new_r[1] & ~tick_r) | (wr_ok && reg_req_in.addr == pid_pkg::OFS_CMD1);
    end
  end

  // phase sequencer: sample on tick, compute terms, then drive power
  // the error gets a cycle of its own so the products below start from a
  // settled register rather than from the subtractor's output
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      phase_r <= pid_pkg::PH_IDLE;
    end else begin
      case (phase_r)
        pid_pkg::PH_IDLE: phase_r <= tick_r ? pid_pkg::PH_CALC : pid_pkg::PH_IDLE;
        pid_pkg::PH_CALC: phase_r <= pid_pkg::PH_OUT;
        pid_pkg::PH_OUT:  phase_r <= pid_pkg::PH_IDLE;
        default:          phase_r <= pid_pkg::PH_IDLE;
      endcase
    end
  end

  // per-channel loop
  // both channels share the gains, limit and sensitivity
  for (genvar c = 0; c < 2; c++) begin : g_chan
    logic signed [31:0] integ_nxt;
    logic signed [31:0] ilim_w;
    logic signed [47:0] sum_nxt;
    logic signed [15:0] diff;

    // integrator step with magnitude bound
    // bounding the sum itself, not its product, keeps windup limited even
    // while the integral gain is being changed
    always_comb begin
      ilim_w    = 32'(ilim_r);
      integ_nxt = integ_r[c] + 32'(err_r[c]);
      if (integ_nxt > ilim_w) begin
        integ_nxt = ilim_w;
      end else if (integ_nxt < -ilim_w) begin
        integ_nxt = -ilim_w;
      end
      diff = err_r[c] - prev_err_r[c];
      // with ki and kd zero this reduces to (desired - actual) * kp
      sum_nxt = (48'(err_r[c]) * 48'(kp_r)
                + 48'(diff) * 48'(kd_r)
                + 48'(integ_nxt) * 48'(ki_r)) >>> pid_pkg::GAIN_FRAC;
    end

    // desired position: trajectory each period, or held command in tracking
    // in tracking a period without a new command leaves the destination alone
    always_ff @(posedge mclk_in) begin
      if (!reset_n_in) begin
        desired_r[c] <= 16'h0000;
        err_r[c]     <= 16'h0000;
      end else if (tick_r) begin
        if (tracking[c]) begin
          if (cmd_new_r[c]) begin
            desired_r[c] <= cmd_r[c];
          end
        end else begin
          desired_r[c] <= traj[c];
        end
      end else if (phase_r == pid_pkg::PH_CALC) begin
        err_r[c] <= desired_r[c] - fb[c];
      end
    end

    // error history, integrator and power output
    // opening the loop clears the integrator, so closing it again starts
    // from a clean sum instead of a stale one
    always_ff @(posedge mclk_in) begin
      if (!reset_n_in) begin
        prev_err_r[c] <= 16'h0000;
        integ_r[c]    <= 32'h0000_0000;
        power_r[c]    <= 16'h0000;
      end else if (!closed[c] || fault_r[c]) begin
        // open loop or faulted: zero power, no windup
        integ_r[c]    <= 32'h0000_0000;
        prev_err_r[c] <= err_r[c];
        power_r[c]    <= 16'h0000;
      end else if (phase_r == pid_pkg::PH_OUT) begin
        integ_r[c]    <= integ_nxt;
        prev_err_r[c] <= err_r[c];
        power_r[c]    <= sat_cmd(sum_nxt);
      end
    end

    // supervisor: error beyond threshold for the whole persistence time
    // the count restarts whenever one period comes in under the threshold,
    // so only an unbroken run of large errors stops the channel; the
    // counter saturates so a long fault cannot wrap it back to zero
    always_ff @(posedge mclk_in) begin
      if (!reset_n_in) begin
        persist_r[c] <= 11'h000;
        fault_r[c]   <= 1'b0;
      end else if (!closed[c]) begin
        persist_r[c] <= 11'h000;
        fault_r[c]   <= 1'b0;
      end else if (phase_r == pid_pkg::PH_OUT) begin
        if (err_mag(err_r[c]) > lim_err) begin
          persist_r[c] <= (persist_r[c] == 11'h7FF) ? persist_r[c] : persist_r[c] + 11'h001;
          if (persist_r[c] + 11'h001 >= lim_ticks) begin
            fault_r[c] <= 1'b1;
          end
        end else begin
          persist_r[c] <= 11'h000;
          fault_r[c]   <= 1'b0;
        end
      end
    end

    // one-cycle pulse in the period where a fault first appears
    assign fault_set[c] = (phase_r == pid_pkg::PH_OUT) && closed[c] && !fault_r[c]
                          && err_mag(err_r[c]) > lim_err && persist_r[c] + 11'h001 >= lim_ticks;
  end

  // sticky status, write one to clear; a new event wins over the clear
  // so an event landing beside the clearing write is never lost
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      stat_r <= 3'h0;
    end else begin
      stat_r <= (stat_r & ~((wr_ok && reg_req_in.addr == pid_pkg::OFS_STAT) ? reg_req_in.wdata[2:0] : 3'h0))
                | {tick_r, fault_set};
    end
  end

  // level interrupt from unmasked status
  // one cycle behind the status bits, the price of a clean flop output
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(stat_r & mask_r);
    end
  end

  // read data one cycle after the strobe, zero otherwise and when unmapped
  // unmapped indices answer zero, so software can probe the map safely
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else if (reg_req_in.rd) begin
      case (reg_req_in.addr)
        pid_pkg::OFS_CTRL: reg_rdata_out <= ctrl_r;
        pid_pkg::OFS_KP:   reg_rdata_out <= {16'h0000, kp_r};
        pid_pkg::OFS_KI:   reg_rdata_out <= {16'h0000, ki_r};
        pid_pkg::OFS_KD:   reg_rdata_out <= {16'h0000, kd_r};
        pid_pkg::OFS_ILIM: reg_rdata_out <= {16'h0000, ilim_r};
        pid_pkg::OFS_CMD0: reg_rdata_out <= {16'h0000, cmd_r[0]};
        pid_pkg::OFS_CMD1: reg_rdata_out <= {16'h0000, cmd_r[1]};
        pid_pkg::OFS_STAT: reg_rdata_out <= {27'h0, fault_r, stat_r};
        pid_pkg::OFS_MASK: reg_rdata_out <= {29'h0, mask_r};
        pid_pkg::OFS_PWR0: reg_rdata_out <= {16'h0000, power_r[0]};
        pid_pkg::OFS_PWR1: reg_rdata_out <= {16'h0000, power_r[1]};
        pid_pkg::OFS_ERR0: reg_rdata_out <= {16'h0000, err_r[0]};
        pid_pkg::OFS_ERR1: reg_rdata_out <= {16'h0000, err_r[1]};
        default:           reg_rdata_out <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_out <= 32'h0000_0000;
    end
  end

  // outputs straight from flip-flops
  // one more cycle of delay, so no pin sees the decode logic
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      power0_out   <= 16'h0000;
      power1_out   <= 16'h0000;
      loop_err_out <= 2'h0;
    end else begin
      power0_out   <= power_r[0];
      power1_out   <= power_r[1];
      loop_err_out <= fault_r;
    end
  end

endmodule : closed_loop_position_pid

`default_nettype wire

// *** closed_loop_position_pid_properties.sv ***
// port assertions for the closed-loop position regulator
`timescale 1ns/10ps
`default_nettype none
module pid_port_checker (
  // clock and reset
  input wire logic               mclk_in,
  input wire logic               reset_n_in,
  // watched ports
  input wire pid_pkg::reg_req_t  reg_req_in,
  input wire logic [31:0]        reg_rdata_out,
  input wire logic signed [15:0] power0_out,
  input wire logic signed [15:0] power1_out,
  input wire logic [1:0]         loop_err_out,
  input wire logic               irq_out
);
  localparam int FAULT_MIN = 6250000;
  localparam int GAP_MIN   = 24999;
  localparam int OPEN_MIN  = 25005;
  logic [22:0] up_r;
  logic [15:0] gap_r;
  logic [15:0] open_r;
  logic [1:0]  cl_r;
  logic [15:0] kp_r;
  logic [2:0]  mask_r;

  // cycle counters; saturate so a long run stays quiet
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      up_r   <= '0;
      gap_r  <= '1;
      open_r <= '0;
    end else begin
      up_r   <= (up_r == '1) ? up_r : up_r + 23'h1;
      // only moves to a non-zero value restart it: an open-loop zero may land anywhere
      gap_r  <= ($changed(power0_out) && power0_out != 16'sh0000) ? 16'h0
                : ((gap_r == '1) ? gap_r : gap_r + 16'h1);
      open_r <= (cl_r != 2'b00) ? 16'h0 : ((open_r == '1) ? open_r : open_r + 16'h1);
    end
  end

  // mirrors of the few registers the properties lean on
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      cl_r   <= 2'b00;
      kp_r   <= pid_pkg::KP_RST;
      mask_r <= 3'h0;
    end else if (reg_req_in.wr) begin
      if (reg_req_in.addr == pid_pkg::OFS_CTRL) cl_r <= reg_req_in.wdata[1:0];
      if (reg_req_in.addr == pid_pkg::OFS_KP) kp_r <= reg_req_in.wdata[15:0];
      if (reg_req_in.addr == pid_pkg::OFS_MASK) mask_r <= reg_req_in.wdata[2:0];
    end
  end

  default clocking dc @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);

  a_read_idle_zero: assert property (!$past(reg_req_in.rd) |-> reg_rdata_out == 32'h0)
    else $error("read data not zero outside a read answer");
  a_gain_read_back: assert property ($past(reg_req_in.rd && reg_req_in.addr == pid_pkg::OFS_KP)
    |-> reg_rdata_out == {16'h0000, kp_r}) else $error("gain read back wrong");
  a_power_in_range: assert property (power0_out >= pid_pkg::POS_MIN && power0_out <= pid_pkg::POS_MAX
    && power1_out >= pid_pkg::POS_MIN && power1_out <= pid_pkg::POS_MAX) else $error("power out of range");
  a_power_once_period: assert property ($changed(power0_out) && power0_out != 16'sh0000
    |-> gap_r >= GAP_MIN) else $error("power changed twice in one period");
  a_open_loop_zero: assert property (open_r >= OPEN_MIN
    |-> power0_out == 16'sh0000 && power1_out == 16'sh0000) else $error("power while open loop");
  a_fault_stops_motor: assert property (loop_err_out[0] [*8] |-> power0_out == 16'sh0000)
    else $error("power while loop fault");
  a_fault_not_early: assert property (loop_err_out != 2'b00 |-> up_r >= FAULT_MIN)
    else $error("loop fault before shortest persistence");
  a_irq_masked_low: assert property ((mask_r == 3'h0) [*2] |-> !irq_out)
    else $error("interrupt while all masked");

  c_irq_rise: cover property ($rose(irq_out));
  c_power_move: cover property ($changed(power0_out) && power0_out != 16'sh0000);
  c_power_read: cover property (reg_req_in.rd && reg_req_in.addr == pid_pkg::OFS_PWR0);
endmodule : pid_port_checker

bind closed_loop_position_pid pid_port_checker u_checker (
  .mclk_in(mclk_in), .reset_n_in(reset_n_in), .reg_req_in(reg_req_in), .reg_rdata_out(reg_rdata_out),
  .power0_out(power0_out), .power1_out(power1_out), .loop_err_out(loop_err_out), .irq_out(irq_out));
`default_nettype wire

// *** motor_feedback_model.sv ***
// feedback sensor of a held load plus the trajectory source, both channels
`timescale 1ns/10ps
`default_nettype none
module motor_feedback_model (
  // clock
  input  wire logic                mclk_in,
  // where the load sits and where the profile points
  input  wire logic signed [15:0]  pos0_in,
  input  wire logic signed [15:0]  pos1_in,
  input  wire logic signed [15:0]  traj0_in,
  input  wire logic signed [15:0]  traj1_in,
  // samples to the regulator
  output var pid_pkg::chan_in_t    chan0_out,
  output var pid_pkg::chan_in_t    chan1_out
);
  // load held still, so feedback shows no motion from the power command
  always_ff @(posedge mclk_in) begin
    chan0_out <= {pos0_in, traj0_in};
    chan1_out <= {pos1_in, traj1_in};
  end
endmodule : motor_feedback_model
`default_nettype wire

// *** closed_loop_position_pid_bench.sv ***
// self-checking bench: register reads, loop terms, tick interrupt
`timescale 1ns/10ps
`default_nettype none
module closed_loop_position_pid_bench;
  logic               mclk_in    = 1'b0;
  logic               reset_n_in = 1'b0;
  pid_pkg::reg_req_t  reg_req_in = '0;
  logic [31:0]        reg_rdata_out;
  pid_pkg::chan_in_t  chan0_in;
  pid_pkg::chan_in_t  chan1_in;
  logic signed [15:0] power0_out;
  logic signed [15:0] power1_out;
  logic [1:0]         loop_err_out;
  logic               irq_out;
  logic signed [15:0] pos0 = 16'sh0000;
  logic signed [15:0] pos1 = 16'sh0000;
  logic signed [15:0] traj0 = 16'sh0000;
  logic signed [15:0] traj1 = 16'sh0000;
  logic [35:0]        note_q[$];
  logic [35:0]        note;
  logic               rd_d = 1'b0;
  int                 errors = 0;
  int                 n_tests = 0;

  // 25 MHz
  always #20 mclk_in = ~mclk_in;

  closed_loop_position_pid DUT (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .reg_req_in(reg_req_in),
    .reg_rdata_out(reg_rdata_out), .chan0_in(chan0_in), .chan1_in(chan1_in), .power0_out(power0_out),
    .power1_out(power1_out), .loop_err_out(loop_err_out), .irq_out(irq_out));
  motor_feedback_model u_load (.mclk_in(mclk_in), .pos0_in(pos0), .pos1_in(pos1), .traj0_in(traj0),
    .traj1_in(traj1), .chan0_out(chan0_in), .chan1_out(chan1_in));

  function automatic int rnd();
    return int'($urandom_range(32'h3E8)) - 32'sh1F4;
  endfunction : rnd
  function automatic int clip(input int v, input int l);
    return (v > l) ? l : ((v < -l) ? -l : v);
  endfunction : clip
  function automatic logic [31:0] w16(input int v);
    return {16'h0000, 16'(v)};
  endfunction : w16
  // 8.8 product back to integer, then saturated to full scale
  function automatic logic [31:0] pw(input int v);
    return w16(clip(v >>> 8, int'(pid_pkg::POS_MAX)));
  endfunction : pw

  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, s);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    reg_req_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk_in);
    reg_req_in.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    note_q.push_back({a, e});
    @(posedge mclk_in);
    reg_req_in <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge mclk_in);
    reg_req_in.rd <= 1'b0;
  endtask : rd
  // clear the tick flag, wait for the tick interrupt, let the period settle
  task automatic sync();
    int n;
    wr(pid_pkg::OFS_STAT, 32'h4);
    repeat (2) @(posedge mclk_in);
    for (n = 0; n < 26000 && irq_out !== 1'b1; n++) @(posedge mclk_in);
    chk("tick irq", 32'h1, {31'h0, irq_out});
    repeat (8) @(posedge mclk_in);
  endtask : sync
  task automatic tally_and_finish();
    if (errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  // read answers stand one cycle; oldest note is the one they answer
  always @(posedge mclk_in) begin
    if (rd_d) begin
      note = note_q.pop_front();
      chk($sformatf("reg %h", note[35:32]), note[31:0], reg_rdata_out);
    end
    rd_d <= reg_req_in.rd;
  end

  // three periods of 25000 cycles plus margin, inside the run budget
  initial begin
    #(40 * 90000);
    errors++;
    tally_and_finish();
  end

  initial begin
    int kp, ki, kd, lim, cmd1, a0, a1, b1, ig0;
    void'($urandom(32'h6E98));
    repeat (2) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    // reset values; unmapped write must vanish
    wr(4'hF, 32'hFFFF_FFFF);
    rd(pid_pkg::OFS_CTRL, pid_pkg::CTRL_RST);
    rd(pid_pkg::OFS_KP, w16(pid_pkg::KP_RST));
    rd(pid_pkg::OFS_KI, 32'h0);
    rd(pid_pkg::OFS_KD, 32'h0);
    rd(pid_pkg::OFS_ILIM, w16(pid_pkg::ILIM_RST));
    rd(pid_pkg::OFS_MASK, 32'h0);
    rd(4'hF, 32'h0);
    wr(pid_pkg::OFS_MASK, 32'h4);
    sync();
    rd(pid_pkg::OFS_PWR0, 32'h0);
    // close both loops, channel 1 tracks a command it already sits on
    kp = $urandom_range(32'h2FF, 32'h40);
    lim = $urandom_range(32'h60, 32'h20);
    cmd1 = rnd();
    pos0 <= 16'(rnd());
    traj0 <= 16'(rnd());
    pos1 <= 16'(cmd1);
    traj1 <= 16'(rnd());
    wr(pid_pkg::OFS_CTRL, 32'h1B);
    wr(pid_pkg::OFS_KP, kp);
    wr(pid_pkg::OFS_ILIM, lim);
    wr(pid_pkg::OFS_CMD1, w16(cmd1));
    sync();
    a0 = traj0 - pos0;
    ig0 = clip(a0, lim);
    rd(pid_pkg::OFS_ERR0, w16(a0));
    rd(pid_pkg::OFS_PWR0, pw(a0 * kp));
    rd(pid_pkg::OFS_PWR1, 32'h0);
    // new samples, feedback past full scale, trajectory ignored by tracking
    ki = $urandom_range(32'h80, 32'h10);
    kd = $urandom_range(32'h200, 32'h40);
    pos0 <= 16'(rnd());
    traj0 <= 16'(rnd());
    pos1 <= 16'sh0600;
    traj1 <= 16'(rnd());
    wr(pid_pkg::OFS_KI, ki);
    wr(pid_pkg::OFS_KD, kd);
    sync();
    a1 = traj0 - pos0;
    b1 = cmd1 - int'(pid_pkg::POS_MAX);
    rd(pid_pkg::OFS_ERR0, w16(a1));
    rd(pid_pkg::OFS_ERR1, w16(b1));
    rd(pid_pkg::OFS_PWR0, pw(a1 * kp + (a1 - a0) * kd + clip(ig0 + a1, lim) * ki));
    rd(pid_pkg::OFS_PWR1, pw(b1 * kp + b1 * kd + clip(b1, lim) * ki));
    chk("power0", pw(a1 * kp + (a1 - a0) * kd + clip(ig0 + a1, lim) * ki), {16'h0000, power0_out});
    chk("power1", pw(b1 * kp + b1 * kd + clip(b1, lim) * ki), {16'h0000, power1_out});
    chk("loop err", 32'h0, {30'h0, loop_err_out});
    // pending tick flag: mask drops the line, one-write clears the flag
    rd(pid_pkg::OFS_STAT, 32'h4);
    wr(pid_pkg::OFS_MASK, 32'h0);
    repeat (2) @(posedge mclk_in);
    chk("irq masked", 32'h0, {31'h0, irq_out});
    wr(pid_pkg::OFS_STAT, 32'h4);
    rd(pid_pkg::OFS_STAT, 32'h0);
    repeat (3) @(posedge mclk_in);
    tally_and_finish();
  end
endmodule : closed_loop_position_pid_bench
`default_nettype wire
